/* File: design/sfsp_regs.svh */
// constants of the flow-through burst sram port
`ifndef SFSP_REGS_SVH
`define SFSP_REGS_SVH

`define SFSP_ADDR_W     18
`define SFSP_DATA_W     36
`define SFSP_LANES      4
`define SFSP_LANE_W     9
`define SFSP_DEPTH      262144
`define SFSP_BURST_W    2
`define SFSP_CLK_PS     20000
`define SFSP_ACCESS_PS  6500
`define SFSP_FAST_MHZ   133
// longest access rounds down, never below one cycle
`define SFSP_ACCESS_CYC \
  (((`SFSP_ACCESS_PS) / (`SFSP_CLK_PS)) > 0 ? \
   ((`SFSP_ACCESS_PS) / (`SFSP_CLK_PS)) : 1)

`endif

/* File: design/sfsp_pkg.sv */
// types of the flow-through burst sram port
`include "sfsp_regs.svh"

package sfsp_pkg;
  typedef logic [`SFSP_ADDR_W-1:0]  sfsp_addr_type;
  typedef logic [`SFSP_DATA_W-1:0]  sfsp_word_type;
  typedef logic [`SFSP_LANES-1:0]   sfsp_lane_type;
  typedef logic [`SFSP_BURST_W-1:0] sfsp_cnt_type;
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } sfsp_op_type;
endpackage : sfsp_pkg

/* File: design/sfsp_sram_port.sv */
// flow-through burst sram, 256k x 36, with registered control and bursts
//
// Notes on behaviour
// - address, selects, write strobe, lanes and data are taken at clk rise.
// - with cycle_suspend_n high the edge is ignored and all state holds.
// - reads and writes follow back to back in any mix, one word per cycle.
// - no wait state is ever inserted, up to the fastest clock grade.
// - a write updates only the byte lanes whose lane_write_n is low.
// - a write commits on its own clock edge with no extra pulse timing.
// - data drivers are off during the data phase of every write.
// - the part selects itself only from the three sampled selects.
// - output enable gates the data drivers without waiting for the clock.
// - burst_linear_i picks linear or interleaved burst address order.
// - sleep request or a deselect puts the part into low power.
// - the array holds 256k words of 36 bits.
// - the two low address bits set the burst start; a two-bit burst counter cleared at load steps from it.
`timescale 1ns/1ns
`default_nettype none
`include "sfsp_regs.svh"

module sfsp_sram_port (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // cycle control
  input  wire logic                  cycle_suspend_n_i,
  input  wire logic                  select_first_n_i,
  input  wire logic                  select_second_i,
  input  wire logic                  select_third_n_i,
  input  wire logic                  adv_load_i,
  input  wire logic                  write_n_i,
  input  wire sfsp_pkg::sfsp_lane_type lane_write_n_i,
  input  wire sfsp_pkg::sfsp_addr_type addr_i,
  // configuration and power
  input  wire logic                  burst_linear_i,
  input  wire logic                  sleep_request_i,
  input  wire logic                  out_enable_n_i,
  // data pins, split into in, out and enable
  input  wire sfsp_pkg::sfsp_word_type data_i,
  output logic [`SFSP_DATA_W-1:0]    data_o,
  output logic                       data_oe_o,
  // status
  output logic                       low_power_o
);
  import sfsp_pkg::*;

  sfsp_word_type mem_r [0:`SFSP_DEPTH-1];

  sfsp_op_type   op_r,    op_nxt;
  sfsp_addr_type addr_r,  addr_nxt;
  sfsp_lane_type lanes_r, lanes_nxt;
  sfsp_cnt_type  cnt_r,   cnt_nxt;
  logic          wr_en_nxt;
  sfsp_addr_type eff_addr;
  sfsp_word_type cur_word;
  sfsp_word_type merged;
  logic          take;
  logic          selected;

  function automatic sfsp_cnt_type burst_low(input sfsp_cnt_type base,
                                             input sfsp_cnt_type cnt,
                                             input logic linear);
    if (linear)
      burst_low = sfsp_cnt_type'(base + cnt);
    else
      burst_low = base ^ cnt;
  endfunction : burst_low

  // edge counts only with suspend low
  assign take     = ~cycle_suspend_n_i;
  assign selected = ~select_first_n_i & select_second_i
                  & ~select_third_n_i;

  // burst address: upper bits fixed, low two from the counter
  assign eff_addr = {addr_r[`SFSP_ADDR_W-1:`SFSP_BURST_W],
                     burst_low(addr_r[`SFSP_BURST_W-1:0], cnt_r,
                               burst_linear_i)};
  assign cur_word = mem_r[eff_addr];

  // lane merge: a lane keeps its old byte unless its select is low
  generate
    for (genvar ln = 0; ln < `SFSP_LANES; ln++) begin : g_lane
      assign merged[ln*`SFSP_LANE_W +: `SFSP_LANE_W] = lanes_r[ln] ?
        cur_word[ln*`SFSP_LANE_W +: `SFSP_LANE_W] :
        data_i[ln*`SFSP_LANE_W +: `SFSP_LANE_W];
    end
  endgenerate

  always_comb begin
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    lanes_nxt = lanes_r;
    cnt_nxt   = cnt_r;
    wr_en_nxt = 1'b0;
    if (take) begin
      // write data arrives one edge after its address
      wr_en_nxt = (op_r == OP_WRITE);
      if (sleep_request_i) begin
        op_nxt = OP_IDLE;
      end else if (adv_load_i) begin
        // advance continues the running op; idle stays idle
        cnt_nxt   = sfsp_cnt_type'(cnt_r + 2'h1);
        lanes_nxt = lane_write_n_i;
      end else if (selected) begin
        op_nxt    = write_n_i ? OP_READ : OP_WRITE;
        addr_nxt  = addr_i;
        lanes_nxt = lane_write_n_i;
        cnt_nxt   = '0;
      end else begin
        op_nxt = OP_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      op_r    <= OP_IDLE;
      addr_r  <= '0;
      lanes_r <= '1;
      cnt_r   <= '0;
    end else begin
      op_r    <= op_nxt;
      addr_r  <= addr_nxt;
      lanes_r <= lanes_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // array is not reset; contents survive reset like a real part
  always_ff @(posedge clk_i) begin
    if (rstn_i && wr_en_nxt)
      mem_r[eff_addr] <= merged;
  end

  // flow-through read: no output stage, data valid within the cycle
  assign data_o = cur_word;

  // drivers: read phase only, and gated by output enable at once
  always_comb begin
    unique case (op_r)
      OP_READ:  data_oe_o = ~out_enable_n_i & ~sleep_request_i;
      OP_WRITE: data_oe_o = 1'b0;
      default:  data_oe_o = 1'b0;
    endcase
  end

  assign low_power_o = sleep_request_i | (op_r == OP_IDLE);

  suspend_hold_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    cycle_suspend_n_i |=> $stable(op_r) && $stable(addr_r)
                          && $stable(cnt_r))
    else $error("state moved on a suspended edge");

  load_capture_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && !sleep_request_i && !adv_load_i && selected
      |=> addr_r == $past(addr_i) && cnt_r == 2'h0
          && op_r == ($past(write_n_i) ? OP_READ : OP_WRITE))
    else $error("selected load not captured");

  deselect_idle_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && !adv_load_i && !selected |=> op_r == OP_IDLE && low_power_o)
    else $error("deselect did not idle the part");

  write_quiet_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && !sleep_request_i && !adv_load_i && selected && !write_n_i
      |=> !data_oe_o)
    else $error("drivers on during write data phase");

  oe_gate_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    out_enable_n_i |-> !data_oe_o)
    else $error("drivers on with output enable high");

  read_flow_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && !sleep_request_i && !adv_load_i && selected && write_n_i
      |=> (out_enable_n_i || sleep_request_i || data_oe_o)
          && data_o == mem_r[$past(addr_i)])
    else $error("read data not flowing through");

  sleep_power_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    sleep_request_i && take |=> op_r == OP_IDLE && low_power_o)
    else $error("sleep did not power down");

  burst_step_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && !sleep_request_i && adv_load_i && op_r != OP_IDLE
      |=> cnt_r == sfsp_cnt_type'($past(cnt_r) + 2'h1) && $stable(op_r))
    else $error("burst counter did not step");

  burst_order_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    op_r != OP_IDLE |-> eff_addr[1:0] == (burst_linear_i ?
      sfsp_cnt_type'(addr_r[1:0] + cnt_r) : (addr_r[1:0] ^ cnt_r)))
    else $error("burst address order wrong");

  // a full-lane write must land at its own data edge, no wait state
  back_to_back_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && op_r == OP_WRITE && lanes_r == '0
      |=> mem_r[$past(eff_addr)] == $past(data_i))
    else $error("write commit dropped");

  idle_dark_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    op_r == OP_IDLE |-> !data_oe_o && low_power_o)
    else $error("idle part drives or is awake");

  sleep_dark_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    sleep_request_i |-> !data_oe_o && low_power_o)
    else $error("sleeping part drives data");

  advance_idle_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    take && !sleep_request_i && adv_load_i && op_r == OP_IDLE
      |=> op_r == OP_IDLE)
    else $error("advance woke an idle part");

endmodule : sfsp_sram_port
`default_nettype wire

/* File: test/sfsp_host_model.sv */
// host controller model that drives the sram port pins
`timescale 1ns/1ns
`default_nettype none
module sfsp_host_model (
  // clock
  input  wire logic clk_i
);
  import sfsp_pkg::*;
  logic          sus_n = 1'b0;
  logic          sel1_n = 1'b0;
  logic          sel2 = 1'b1;
  logic          sel3_n = 1'b0;
  logic          adv = 1'b1; // idle until first load
  logic          wr_n = 1'b1;
  logic          lin = 1'b1;
  logic          sleep = 1'b0;
  logic          oe_n = 1'b0;
  logic          pend = 1'b0;
  sfsp_lane_type lanes = 4'hf;
  sfsp_addr_type addr = 18'h0;
  sfsp_word_type wdata = 36'h0;
  // change at the fall, hold through the rise; idle data bus toggles
  task automatic cyc(input logic a, input logic w, input sfsp_addr_type ad,
                     input sfsp_lane_type ln, input sfsp_word_type d);
    @(negedge clk_i);
    wdata = pend ? d : ~wdata;
    pend  = a ? pend : !w;
    adv   = a;
    wr_n  = w;
    lanes = ln;
    addr  = ad;
    #1;
  endtask : cyc
endmodule : sfsp_host_model
`default_nettype wire

/* File: test/sfsp_sram_port_bench.sv */
// self-checking bench of the flow-through sram port
`timescale 1ns/1ns
`default_nettype none
module sfsp_sram_port_bench;
  import sfsp_pkg::*;
  logic          clk = 1'b0;
  logic          rstn = 1'b0;
  logic          oe;
  logic          lp;
  int            error_cnt = 0;
  int            num_checks = 0;
  sfsp_word_type rd;
  sfsp_word_type w[4] = '{36'h123456789, 36'hfedcba987, 36'h0a5a5a5a5,
                          36'h5c3c3c3c3};
  always #10 clk = ~clk;
  sfsp_host_model i_host (.clk_i(clk));
  sfsp_sram_port i_dut (
    .clk_i            (clk),
    .rstn_i           (rstn),
    .cycle_suspend_n_i(i_host.sus_n),
    .select_first_n_i (i_host.sel1_n),
    .select_second_i  (i_host.sel2),
    .select_third_n_i (i_host.sel3_n),
    .adv_load_i       (i_host.adv),
    .write_n_i        (i_host.wr_n),
    .lane_write_n_i   (i_host.lanes),
    .addr_i           (i_host.addr),
    .burst_linear_i   (i_host.lin),
    .sleep_request_i  (i_host.sleep),
    .out_enable_n_i   (i_host.oe_n),
    .data_i           (i_host.wdata),
    .data_o           (rd),
    .data_oe_o        (oe),
    .low_power_o      (lp)
  );
  task automatic cmp_w(string n, sfsp_word_type e, sfsp_word_type s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_w
  task automatic cmp_b(string n, logic e, logic s);
    cmp_w(n, {35'h0, e}, {35'h0, s});
  endtask : cmp_b
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    cmp_b("low_power", 1'b1, lp);
    cmp_b("drive_en", 1'b0, oe);
    $display("test reset done");
    // four writes then reads, no idle cycle at the turn
    for (int i = 0; i < 9; i++) begin
      i_host.cyc(1'b0, i > 3, 18'((i + 3) % 4), 4'h0, w[(i + 2) % 4]);
      if (i > 4) cmp_w("read", w[(i + 2) % 4], rd);
      if (i > 0) cmp_b("drive_en", i > 4, oe);
    end
    $display("test back to back done");
    for (int m = 0; m < 2; m++) begin
      i_host.lin = m[0];
      i_host.cyc(1'b0, 1'b1, 18'h1, 4'hf, 36'h0);
      for (int k = 0; k < 4; k++) begin
        i_host.cyc(k < 3, 1'b1, 18'h0, 4'hf, 36'h0);
        cmp_w("burst", w[m ? (k + 1) % 4 : 1 ^ k], rd);
      end
    end
    $display("test burst done");
    i_host.cyc(1'b0, 1'b1, 18'h2, 4'hf, 36'h0);
    i_host.cyc(1'b0, 1'b1, 18'h3, 4'hf, 36'h0);
    i_host.sus_n = 1'b1;
    i_host.cyc(1'b0, 1'b1, 18'h3, 4'hf, 36'h0);
    cmp_w("suspend", w[2], rd);
    i_host.sus_n = 1'b0;
    i_host.cyc(1'b0, 1'b1, 18'h3, 4'hf, 36'h0);
    cmp_w("resume", w[3], rd);
    $display("test suspend done");
    i_host.cyc(1'b0, 1'b0, 18'h0, 4'ha, 36'h0);
    i_host.cyc(1'b0, 1'b1, 18'h0, 4'hf, 36'h0);
    i_host.cyc(1'b0, 1'b1, 18'h0, 4'hf, 36'h0);
    cmp_w("lanes", w[0] & 36'hff803fe00, rd);
    i_host.oe_n = 1'b1;
    #1 cmp_b("out_enable", 1'b0, oe);
    i_host.oe_n = 1'b0;
    #1 cmp_b("out_enable", 1'b1, oe);
    $display("test lanes done");
    // each select false in turn, then sleep, then all back on
    for (int s = 0; s < 5; s++) begin
      i_host.sel1_n = s == 0;
      i_host.sel2 = s != 1;
      i_host.sel3_n = s == 2;
      i_host.sleep = s == 3;
      i_host.cyc(1'b0, 1'b1, 18'h0, 4'hf, 36'h0);
      i_host.cyc(1'b0, 1'b1, 18'h0, 4'hf, 36'h0);
      cmp_b("low_power", s < 4, lp);
      cmp_b("drive_en", s > 3, oe);
    end
    $display("test select done");
    finish_test();
  end
endmodule : sfsp_sram_port_bench
`default_nettype wire
